// ### src/gp_timer_pkg.sv
package gp_timer_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] CONTROL_IDX = 6'h00;
  localparam logic [5:0] MODE_IDX = 6'h02;
  localparam logic [5:0] FLAGS_IDX = 6'h04;
  localparam logic [5:0] IRQ_EN_IDX = 6'h06;
  localparam logic [5:0] COMPARE1_IDX = 6'h08;
  localparam logic [5:0] COMPARE3_IDX = 6'h0a;
  localparam logic [5:0] COMPARE4_IDX = 6'h0c;
  localparam logic [5:0] CAPTURE1_IDX = 6'h0e;
  localparam logic [5:0] CAPTURE2_IDX = 6'h10;
  localparam logic [5:0] PWM_COMPARE_IDX = 6'h12;
  localparam logic [5:0] TIMER_COUNT_IDX = 6'h14;
  localparam logic [5:0] PWM_MODULUS_IDX = 6'h16;
  localparam logic [5:0] PWM_COUNT_IDX = 6'h18;
  // control register field positions
  localparam int CTL_TSEL_LSB = 0;
  localparam int CTL_PSEL_LSB = 3;
  localparam int CTL_TIMER_RUN = 6;
  localparam int CTL_TIMER_DOZE = 7;
  localparam int CTL_PWM_RUN = 8;
  localparam int CTL_PWM_DOZE = 9;
  localparam int CTL_TIMER_DBG = 10;
  localparam int CTL_PWM_DBG = 11;
  localparam logic [15:0] CTL_MASK = 16'h0fff;
  // mode register field positions
  localparam int MODE_ACTION_LSB = 0;
  localparam int MODE_EDGE1_LSB = 6;
  localparam int MODE_EDGE2_LSB = 8;
  localparam int MODE_FORCE1 = 10;
  localparam int MODE_POLARITY = 13;
  localparam int MODE_CONNECT = 14;
  localparam logic [15:0] MODE_MASK = 16'h63c3;
  // flag and enable bit positions
  localparam int FLAG_COMPARE_LSB = 0;
  localparam int FLAG_CAPTURE_LSB = 3;
  localparam int FLAG_PWM_COMPARE = 5;
  localparam int FLAG_OVERFLOW = 6;
  localparam int FLAG_ROLLOVER = 7;
  // edge select and pin action encodings
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  localparam logic [7:0] DIV_ALL_ONES = 8'hff;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // apb request and answer bundles
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } apb_req_type;
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } apb_rsp_type;
  // whole block state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] mode;
    logic [7:0] flags;
    logic [7:0] irq_en;
    logic [2:0][15:0] cmp;
    logic [1:0][15:0] cap;
    logic [15:0] pwm_cmp;
    logic [15:0] pwm_mod;
    logic [15:0] tcount;
    logic [15:0] pcount;
    logic [7:0] div;
    logic [2:0] tsel;
    logic [2:0] psel;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] samp;
    logic [1:0] filt;
    logic prev_pwm_run;
    logic cmp_pin;
    logic pwm_active;
    logic pwm_pin;
    logic irq;
    apb_rsp_type rsp;
  } state_type;
endpackage : gp_timer_pkg

// ### src/gp_timer_pwm.sv
// Operation
// - shared 8-bit divider clocks both counters
// - new prescale applied at divider rollover
// - timer counts up while run, holds otherwise
// - timer freezes in stop, doze, debug
// - capture inputs: uart rxd and rts
// - capture edge rising, falling or both
// - edge latches count, sets flag, irq
// - inputs synchronised and filtered, short pulses dropped
// - capture latches hold, reads harmless
// - compare match sets flag and irq
// - channel one match drives pin action
// - force applies pin action, no flag
// - pwm run loads modulus, counts down
// - pwm counter freezes in stop, doze, debug
// - pwm compare sets flag, pin active
// - pwm zero sets flag, pin inactive, reload
// - duty zero at compare zero
// - pwm period two to 65536x256 cycles
// - timer count readable without disturbance
// - edge select encoding 00/01/10/11
// - pin action encoding 00/01/10/11
// - prescaler stops when both counters stopped
`timescale 1ns/100ps
module gp_timer_pwm (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  input wire logic stop_mode_i,
  input wire logic doze_mode_i,
  input wire logic debug_mode_i,
  input wire logic uart_rxd_i,
  input wire logic uart_rts_i,
  output logic compare_pin_o,
  output logic pwm_pin_o,
  output logic timer_irq_o
);
  import gp_timer_pkg::*;

  state_type state_reg; // all block state
  state_type state_next; // next value of all state
  gp_timer_pkg::apb_req_type req; // bundled bus request
  logic access; // bus access phase this cycle
  logic wr_en; // register write takes effect
  logic div_run; // shared prescaler running
  logic t_step; // timer counter advances
  logic p_step; // pwm counter advances
  logic pwm_load; // pwm counter reload on run
  logic force1; // channel one forced action
  logic [1:0] cap_evt; // capture events per channel
  logic [15:0] t_inc; // timer count plus one
  logic [7:0] clr; // flags cleared by write

  // low bits of the divider all ones gives the selected tick
  function automatic logic prescale_tick(input logic [7:0] div, input logic [2:0] sel);
    logic [7:0] lowmask;
    lowmask = DIV_ALL_ONES >> (3'h7 - sel);
    return ((div | ~lowmask) == DIV_ALL_ONES);
  endfunction : prescale_tick

  // pin level after a compare action
  function automatic logic pin_action(input logic [1:0] act, input logic cur);
    logic res;
    res = cur;
    case (act)
      ACT_TOGGLE: res = ~cur;
      ACT_CLEAR: res = 1'b0;
      ACT_SET: res = 1'b1;
      default: res = cur; // disconnected, pin holds
    endcase
    return res;
  endfunction : pin_action

  // edge qualifier from the selected mode
  function automatic logic edge_hit(input logic [1:0] sel, input logic old, input logic cur);
    logic res;
    res = 1'b0;
    case (sel)
      EDGE_RISE: res = ~old & cur;
      EDGE_FALL: res = old & ~cur;
      EDGE_BOTH: res = old ^ cur;
      default: res = 1'b0; // capture disabled
    endcase
    return res;
  endfunction : edge_hit

  // register index decode from the byte address
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    return (addr[7:2] == idx);
  endfunction : hit

  // bundle the bus inputs
  always_comb begin
    req.sel = psel_i;
    req.enable = penable_i;
    req.write = pwrite_i;
    req.addr = paddr_i;
    req.wdata = pwdata_i;
  end

  // next state of the whole block
  always_comb begin
    logic [15:0] wd;
    logic [7:0] set;
    logic t_frz;
    logic p_frz;
    logic mapped;
    logic [31:0] rd;
    wd = req.wdata[15:0];
    set = 8'h00;
    t_frz = 1'b0;
    p_frz = 1'b0;
    mapped = 1'b0;
    rd = 32'h0000_0000;
    state_next = state_reg;
    // bus answers one cycle after the access phase starts
    access = req.sel & req.enable & ~state_reg.rsp.ready;
    wr_en = access & req.write;
    // shared prescaler, stops only when both counters are off
    div_run = state_reg.ctrl[CTL_TIMER_RUN] | state_reg.ctrl[CTL_PWM_RUN];
    if (div_run) begin
      state_next.div = state_reg.div + 8'h01;
    end
    // select changes are only picked up at divider zero
    if (state_reg.div == 8'h00) begin
      state_next.tsel = state_reg.ctrl[CTL_TSEL_LSB +: 3];
      state_next.psel = state_reg.ctrl[CTL_PSEL_LSB +: 3];
    end
    // freeze conditions per counter
    t_frz = stop_mode_i | (doze_mode_i & state_reg.ctrl[CTL_TIMER_DOZE])
      | (debug_mode_i & state_reg.ctrl[CTL_TIMER_DBG]);
    p_frz = stop_mode_i | (doze_mode_i & state_reg.ctrl[CTL_PWM_DOZE])
      | (debug_mode_i & state_reg.ctrl[CTL_PWM_DBG]);
    t_step = div_run & prescale_tick(state_reg.div, state_reg.tsel)
      & state_reg.ctrl[CTL_TIMER_RUN] & ~t_frz;
    p_step = div_run & prescale_tick(state_reg.div, state_reg.psel)
      & state_reg.ctrl[CTL_PWM_RUN] & ~p_frz;
    // timer counter, wraps through zero
    t_inc = state_reg.tcount + 16'h0001;
    if (t_step) begin
      state_next.tcount = t_inc;
      if (state_reg.tcount == COUNT_ALL_ONES) begin
        set[FLAG_OVERFLOW] = 1'b1;
      end
      // compare channels checked on each new count
      for (int i = 0; i < 3; i++) begin
        if (t_inc == state_reg.cmp[i]) begin
          set[FLAG_COMPARE_LSB + i] = 1'b1;
        end
      end
    end
    // compare pin: match or force applies the same action
    force1 = wr_en & hit(req.addr, MODE_IDX) & wd[MODE_FORCE1];
    if ((t_step && t_inc == state_reg.cmp[0]) || force1) begin
      state_next.cmp_pin = pin_action(state_reg.mode[MODE_ACTION_LSB +: 2],
        state_reg.cmp_pin);
    end
    // capture inputs: two-stage synchroniser then stability filter
    state_next.sync1 = {uart_rts_i, uart_rxd_i};
    state_next.sync2 = state_reg.sync1;
    state_next.samp = state_reg.sync2;
    for (int i = 0; i < 2; i++) begin
      if (state_reg.sync2[i] == state_reg.samp[i]) begin
        state_next.filt[i] = state_reg.sync2[i];
      end
    end
    cap_evt[0] = state_reg.ctrl[CTL_TIMER_RUN] & edge_hit(
      state_reg.mode[MODE_EDGE1_LSB +: 2], state_reg.filt[0], state_next.filt[0]);
    cap_evt[1] = state_reg.ctrl[CTL_TIMER_RUN] & edge_hit(
      state_reg.mode[MODE_EDGE2_LSB +: 2], state_reg.filt[1], state_next.filt[1]);
    for (int i = 0; i < 2; i++) begin
      if (cap_evt[i]) begin
        state_next.cap[i] = state_reg.tcount;
        set[FLAG_CAPTURE_LSB + i] = 1'b1;
      end
    end
    // pwm down counter
    state_next.prev_pwm_run = state_reg.ctrl[CTL_PWM_RUN];
    pwm_load = state_reg.ctrl[CTL_PWM_RUN] & ~state_reg.prev_pwm_run;
    if (pwm_load) begin
      state_next.pcount = state_reg.pwm_mod;
    end else if (p_step) begin
      if (state_reg.pcount == state_reg.pwm_cmp) begin
        set[FLAG_PWM_COMPARE] = 1'b1;
        state_next.pwm_active = 1'b1;
      end
      if (state_reg.pcount == 16'h0000) begin
        // zero wins over a compare at zero, giving zero duty
        set[FLAG_ROLLOVER] = 1'b1;
        state_next.pwm_active = 1'b0;
        state_next.pcount = state_reg.pwm_mod;
      end else begin
        state_next.pcount = state_reg.pcount - 16'h0001;
      end
    end
    // pwm pin level with polarity and connection
    state_next.pwm_pin = state_reg.mode[MODE_CONNECT]
      & (state_next.pwm_active ^ state_reg.mode[MODE_POLARITY]);
    // register writes
    clr = 8'h00;
    if (wr_en) begin
      if (hit(req.addr, CONTROL_IDX)) begin
        state_next.ctrl = wd & CTL_MASK;
      end
      if (hit(req.addr, MODE_IDX)) begin
        state_next.mode = wd & MODE_MASK; // force bits never stored
      end
      if (hit(req.addr, FLAGS_IDX)) begin
        clr = wd[7:0];
      end
      if (hit(req.addr, IRQ_EN_IDX)) begin
        state_next.irq_en = wd[7:0];
      end
      if (hit(req.addr, COMPARE1_IDX)) begin
        state_next.cmp[0] = wd;
      end
      if (hit(req.addr, COMPARE3_IDX)) begin
        state_next.cmp[1] = wd;
      end
      if (hit(req.addr, COMPARE4_IDX)) begin
        state_next.cmp[2] = wd;
      end
      if (hit(req.addr, PWM_COMPARE_IDX)) begin
        state_next.pwm_cmp = wd;
      end
      if (hit(req.addr, PWM_MODULUS_IDX)) begin
        state_next.pwm_mod = wd;
      end
    end
    // flags: hardware set wins over the software clear
    state_next.flags = (state_reg.flags & ~clr) | set;
    state_next.irq = |(state_next.flags & state_next.irq_en);
    // read mux, reading changes nothing
    case (req.addr[7:2])
      CONTROL_IDX: rd[15:0] = state_reg.ctrl;
      MODE_IDX: rd[15:0] = state_reg.mode;
      FLAGS_IDX: rd[7:0] = state_reg.flags;
      IRQ_EN_IDX: rd[7:0] = state_reg.irq_en;
      COMPARE1_IDX: rd[15:0] = state_reg.cmp[0];
      COMPARE3_IDX: rd[15:0] = state_reg.cmp[1];
      COMPARE4_IDX: rd[15:0] = state_reg.cmp[2];
      CAPTURE1_IDX: rd[15:0] = state_reg.cap[0];
      CAPTURE2_IDX: rd[15:0] = state_reg.cap[1];
      PWM_COMPARE_IDX: rd[15:0] = state_reg.pwm_cmp;
      TIMER_COUNT_IDX: rd[15:0] = state_reg.tcount;
      PWM_MODULUS_IDX: rd[15:0] = state_reg.pwm_mod;
      PWM_COUNT_IDX: rd[15:0] = state_reg.pcount;
      default: rd = 32'h0000_0000; // unmapped
    endcase
    case (req.addr[7:2])
      CONTROL_IDX, MODE_IDX, FLAGS_IDX, IRQ_EN_IDX, COMPARE1_IDX, COMPARE3_IDX,
      COMPARE4_IDX, CAPTURE1_IDX, CAPTURE2_IDX, PWM_COMPARE_IDX, TIMER_COUNT_IDX,
      PWM_MODULUS_IDX, PWM_COUNT_IDX: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    // answer registered, one wait state
    state_next.rsp.ready = access;
    state_next.rsp.slverr = access & ~mapped;
    state_next.rsp.rdata = (access && !req.write) ? rd : 32'h0000_0000;
  end

  // state register with synchronous reset
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign pready_o = state_reg.rsp.ready;
  assign pslverr_o = state_reg.rsp.slverr;
  assign prdata_o = state_reg.rsp.rdata;
  assign compare_pin_o = state_reg.cmp_pin;
  assign pwm_pin_o = state_reg.pwm_pin;
  assign timer_irq_o = state_reg.irq;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  timer_hold_a: assert property (!state_reg.ctrl[CTL_TIMER_RUN] |=>
    state_reg.tcount == $past(state_reg.tcount))
    else $error("timer count moved while stopped");
  timer_freeze_a: assert property (stop_mode_i |=> $stable(state_reg.tcount))
    else $error("timer count moved in stop mode");
  timer_wrap_a: assert property (t_step && state_reg.tcount == COUNT_ALL_ONES |=>
    state_reg.tcount == 16'h0000 && state_reg.flags[FLAG_OVERFLOW])
    else $error("timer did not wrap to zero");
  capture_copy_a: assert property (cap_evt[0] |=>
    state_reg.cap[0] == $past(state_reg.tcount) && state_reg.flags[FLAG_CAPTURE_LSB])
    else $error("capture one did not latch the count");
  capture_keep_a: assert property (!cap_evt[1] |=> $stable(state_reg.cap[1]))
    else $error("capture two changed without an edge");
  compare_flag_a: assert property (t_step && t_inc == state_reg.cmp[2] |=>
    state_reg.flags[FLAG_COMPARE_LSB + 2])
    else $error("compare four flag not set on match");
  pwm_reload_a: assert property ($rose(state_reg.ctrl[CTL_PWM_RUN]) |=>
    state_reg.pcount == $past(state_reg.pwm_mod))
    else $error("pwm counter not loaded on run");
  pwm_zero_a: assert property (p_step && !pwm_load && state_reg.pcount == 16'h0000 |=>
    !state_reg.pwm_active && state_reg.flags[FLAG_ROLLOVER]
    && state_reg.pcount == $past(state_reg.pwm_mod))
    else $error("pwm zero did not reload and deassert");
  prescale_hold_a: assert property (!div_run |=> $stable(state_reg.div))
    else $error("prescaler ran with both counters off");
  force_flag_a: assert property (force1 && !t_step |=>
    state_reg.flags[FLAG_COMPARE_LSB] == $past(state_reg.flags[FLAG_COMPARE_LSB]))
    else $error("force set the compare flag");

  // timer count reads return the count as it stood at the access edge
  read_data_a: assert property (access && !req.write
    && hit(req.addr, TIMER_COUNT_IDX) |=> prdata_o[15:0] == $past(state_reg.tcount))
    else $error("timer count read returned a wrong value");

  // a channel one match with the set action drives the pin high
  compare_pin_a: assert property (t_step && t_inc == state_reg.cmp[0]
    && state_reg.mode[MODE_ACTION_LSB +: 2] == ACT_SET |=> compare_pin_o)
    else $error("compare match did not set the pin");

  // a lone force with the toggle action flips the pin once
  force_toggle_a: assert property (force1 && !(t_step && t_inc == state_reg.cmp[0])
    && state_reg.mode[MODE_ACTION_LSB +: 2] == ACT_TOGGLE
    |=> compare_pin_o != $past(compare_pin_o))
    else $error("forced toggle did not flip the pin");

  // disconnected action leaves the pin where it was
  pin_hold_a: assert property (state_reg.mode[MODE_ACTION_LSB +: 2] == ACT_NONE
    |=> $stable(compare_pin_o))
    else $error("disconnected compare action moved the pin");

  // capture disabled means the latch never moves
  capture_off_a: assert property (state_reg.mode[MODE_EDGE2_LSB +: 2] == EDGE_OFF
    |=> $stable(state_reg.cap[1]))
    else $error("capture two latched while disabled");

  // filtered level only follows two equal synchronised samples
  filter_stable_a: assert property ($changed(state_reg.filt[0])
    |-> state_reg.samp[0] == state_reg.filt[0]
    && $past(state_reg.samp[0]) == state_reg.filt[0])
    else $error("capture filter passed an unsettled level");

  // pwm compare point away from zero starts the pulse
  pwm_compare_a: assert property (p_step && !pwm_load && state_reg.pcount != 16'h0000
    && state_reg.pcount == state_reg.pwm_cmp |=> state_reg.pwm_active
    && state_reg.flags[FLAG_PWM_COMPARE])
    else $error("pwm compare did not start the pulse");

  // unconnected pwm pin stays low
  pwm_pin_off_a: assert property (!state_reg.mode[MODE_CONNECT] |=> !pwm_pin_o)
    else $error("pwm pin driven while disconnected");

  // pwm counter holds in stop mode unless a run edge reloads it
  pwm_freeze_a: assert property (stop_mode_i && !pwm_load
    |=> $stable(state_reg.pcount))
    else $error("pwm count moved in stop mode");

  // interrupt output mirrors the enabled flags
  irq_level_a: assert property (timer_irq_o == |(state_reg.flags & state_reg.irq_en))
    else $error("interrupt output disagrees with flags");

  // shared divider steps by one while either counter runs
  div_step_a: assert property (div_run |=> state_reg.div == $past(state_reg.div) + 8'h01)
    else $error("prescaler did not advance");
endmodule : gp_timer_pwm

// ### verification/pin_partner.sv
`timescale 1ns/100ps
// far side of the capture inputs: the two uart lines
module pin_partner (
  input wire logic core_clk_i,
  input wire logic rxd_lvl_i,
  input wire logic rts_lvl_i,
  input wire logic glitch_i,
  output logic rxd_o,
  output logic rts_o
);
  logic rxd_q; // settled receive line level
  logic rts_q; // settled request line level
  logic spike; // short pulse laid on both lines
  // uart lines idle high, no spike
  initial begin
    rxd_q = 1'b1;
    rts_q = 1'b1;
    spike = 1'b0;
  end
  // lines move just after the edge, as a real sender would
  always @(posedge core_clk_i) begin
    rxd_q <= rxd_lvl_i;
    rts_q <= rts_lvl_i;
  end
  // 2 ns spike, well under one clock period
  always @(posedge core_clk_i) begin
    if (glitch_i) begin
      #1 spike = 1'b1;
      #2 spike = 1'b0;
    end
  end
  assign rxd_o = rxd_q ^ spike;
  assign rts_o = rts_q ^ spike;
endmodule : pin_partner

// ### verification/gp_timer_pwm_test.sv
`timescale 1ns/100ps
// register traffic over apb plus pin stimulus, self-checking
module gp_timer_pwm_test;
  import gp_timer_pkg::*;
  localparam logic [15:0] TRUN = 16'h0001 << CTL_TIMER_RUN;
  localparam logic [15:0] PRUN = 16'h0001 << CTL_PWM_RUN;
  localparam logic [15:0] DOZ = (16'h0001 << CTL_TIMER_DOZE) | (16'h0001 << CTL_PWM_DOZE);
  localparam logic [15:0] DBG = (16'h0001 << CTL_TIMER_DBG) | (16'h0001 << CTL_PWM_DBG);
  logic core_clk_i; // bench clock
  logic rstn_i; // active low reset
  apb_req_type req; // apb master request
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic stop_m; // low power mode inputs
  logic doze_m;
  logic debug_m;
  logic rxd_lvl; // requested line levels
  logic rts_lvl;
  logic glitch;
  logic rxd;
  logic rts;
  logic cmp_pin;
  logic pwm_pin;
  logic irq;
  int n_mismatch;
  int samples_checked;
  int hi; // high cycles of the pwm pin
  logic [31:0] a; // scratch read values
  logic [31:0] b;
  logic [31:0] c;
  logic [31:0] d;
  logic e;
  // freeze table: mode inputs, control extras, frozen or not
  logic [2:0] mode_tab [5] = '{3'b100, 3'b010, 3'b010, 3'b001, 3'b001};
  logic [15:0] ctl_tab [5] = '{16'h0, 16'h0, DOZ, 16'h0, DBG};
  logic frz_tab [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  // force table: pin action and resulting pin
  logic [1:0] act_tab [5] = '{ACT_SET, ACT_NONE, ACT_TOGGLE, ACT_TOGGLE, ACT_CLEAR};
  logic pin_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  // duty table: compare value, polarity, high cycles in 64
  logic [15:0] cmp_tab [4] = '{16'h1, 16'h1, 16'h0, 16'h3};
  logic pol_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int hi_tab [4] = '{16, 48, 0, 48};
  logic [5:0] rst_tab [5] = '{CONTROL_IDX, MODE_IDX, FLAGS_IDX, IRQ_EN_IDX, TIMER_COUNT_IDX};

  gp_timer_pwm u_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(req.sel), .penable_i(req.enable),
    .pwrite_i(req.write), .paddr_i(req.addr), .pwdata_i(req.wdata), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata), .stop_mode_i(stop_m), .doze_mode_i(doze_m),
    .debug_mode_i(debug_m), .uart_rxd_i(rxd), .uart_rts_i(rts), .compare_pin_o(cmp_pin),
    .pwm_pin_o(pwm_pin), .timer_irq_o(irq)
  );
  pin_partner u_pins (
    .core_clk_i(core_clk_i), .rxd_lvl_i(rxd_lvl), .rts_lvl_i(rts_lvl), .glitch_i(glitch),
    .rxd_o(rxd), .rts_o(rts)
  );

  // 200 mhz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // one apb transfer, request held until pready is seen
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk_i);
    req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: {idx, 2'h0}, wdata: {16'h0, wd}};
    @(posedge core_clk_i);
    req.enable <= 1'b1;
    // pready, prdata and pslverr are taken at the rising edge that sees pready high
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t no bus answer", $time);
    end
    req.sel <= 1'b0;
    req.enable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [5:0] idx, input logic [15:0] wd);
    logic [31:0] x;
    logic y;
    xfer(1'b1, idx, wd, x, y);
  endtask : wr

  task automatic rd(input logic [5:0] idx, output logic [31:0] x);
    logic y;
    xfer(1'b0, idx, 16'h0, x, y);
  endtask : rd

  // compare one value with its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // set edge modes, move the lines, check both capture flags
  task automatic cap(input logic [3:0] ed, input logic r, input logic t, input logic g,
      input logic [1:0] exp);
    logic [31:0] x;
    wr(MODE_IDX, 16'(ed) << MODE_EDGE1_LSB);
    wr(FLAGS_IDX, 16'h00ff);
    rxd_lvl <= r;
    rts_lvl <= t;
    glitch <= g;
    @(posedge core_clk_i);
    glitch <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    rd(FLAGS_IDX, x);
    chk({30'h0, x[4:3]}, {30'h0, exp});
  endtask : cap

  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    rstn_i = 1'b0;
    req = '0;
    {stop_m, doze_m, debug_m} = 3'b000;
    {rxd_lvl, rts_lvl, glitch} = 3'b110;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    // reset values, then an unmapped index
    foreach (rst_tab[i]) begin
      rd(rst_tab[i], a);
      chk(a, 32'h0);
    end
    xfer(1'b0, 6'h3f, 16'h0, a, e);
    chk({a[30:0], e}, 32'h1);
    // count rate for every prescale code
    for (int k = 0; k < 8; k++) begin
      wr(CONTROL_IDX, TRUN | 16'(k));
      repeat (256) @(posedge core_clk_i);
      rd(TIMER_COUNT_IDX, a);
      repeat (256) @(posedge core_clk_i);
      rd(TIMER_COUNT_IDX, b);
      c = 32'(261 >> (k + 1));
      chk({31'h0, (b[15:0] - a[15:0] - c[15:0] + 16'h2) <= 16'h4}, 32'h1);
    end
    // hold while stopped, resume without reload
    wr(CONTROL_IDX, TRUN);
    repeat (256) @(posedge core_clk_i);
    wr(CONTROL_IDX, 16'h0);
    rd(TIMER_COUNT_IDX, a);
    repeat (40) @(posedge core_clk_i);
    rd(TIMER_COUNT_IDX, b);
    chk(b, a);
    wr(CONTROL_IDX, TRUN);
    rd(TIMER_COUNT_IDX, c);
    chk({31'h0, (c[15:0] - a[15:0]) < 16'h8}, 32'h1);
    // freezing under stop, doze and debug
    wr(PWM_MODULUS_IDX, 16'h0fff);
    for (int m = 0; m < 5; m++) begin
      {stop_m, doze_m, debug_m} <= mode_tab[m];
      wr(CONTROL_IDX, TRUN | PRUN | ctl_tab[m]);
      rd(TIMER_COUNT_IDX, a);
      rd(PWM_COUNT_IDX, c);
      repeat (40) @(posedge core_clk_i);
      rd(TIMER_COUNT_IDX, b);
      rd(PWM_COUNT_IDX, d);
      chk({30'h0, a == b, c == d}, {30'h0, frz_tab[m], frz_tab[m]});
    end
    {stop_m, doze_m, debug_m} <= 3'b000;
    // forced pin actions leave the flags alone
    wr(CONTROL_IDX, 16'h0);
    wr(FLAGS_IDX, 16'h00ff);
    for (int i = 0; i < 5; i++) begin
      wr(MODE_IDX, 16'(act_tab[i]));
      wr(MODE_IDX, 16'(act_tab[i]) | (16'h0001 << MODE_FORCE1));
      repeat (2) @(posedge core_clk_i);
      chk({31'h0, cmp_pin}, {31'h0, pin_tab[i]});
    end
    rd(FLAGS_IDX, a);
    chk(a, 32'h0);
    // match on channels 1, 3 and 4
    rd(TIMER_COUNT_IDX, a);
    wr(COMPARE1_IDX, a[15:0] + 16'h8);
    wr(COMPARE3_IDX, a[15:0] + 16'h8);
    wr(COMPARE4_IDX, a[15:0] + 16'h8);
    wr(IRQ_EN_IDX, 16'h0001);
    wr(MODE_IDX, 16'(ACT_SET));
    wr(CONTROL_IDX, TRUN);
    repeat (40) @(posedge core_clk_i);
    rd(FLAGS_IDX, b);
    chk(b & 32'h7, 32'h7);
    chk({30'h0, cmp_pin, irq}, 32'h3);
    wr(FLAGS_IDX, 16'h0001);
    rd(FLAGS_IDX, b);
    chk({30'h0, b[0], irq}, 32'h0);
    // capture edges, encodings and short pulses
    cap({EDGE_FALL, EDGE_RISE}, 1'b0, 1'b0, 1'b0, 2'b10);
    rd(TIMER_COUNT_IDX, a);
    cap({EDGE_FALL, EDGE_RISE}, 1'b1, 1'b1, 1'b0, 2'b01);
    rd(CAPTURE1_IDX, b);
    rd(CAPTURE1_IDX, c);
    rd(TIMER_COUNT_IDX, d);
    chk(b, c);
    chk({31'h0, (b[15:0] - a[15:0]) <= (d[15:0] - a[15:0])}, 32'h1);
    cap({EDGE_OFF, EDGE_BOTH}, 1'b0, 1'b0, 1'b0, 2'b01);
    cap({EDGE_BOTH, EDGE_FALL}, 1'b1, 1'b1, 1'b0, 2'b10);
    cap({EDGE_BOTH, EDGE_BOTH}, 1'b1, 1'b1, 1'b1, 2'b00);
    // pwm duty over compare value and polarity
    wr(CONTROL_IDX, 16'h0);
    wr(PWM_MODULUS_IDX, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      wr(PWM_COMPARE_IDX, cmp_tab[i]);
      wr(MODE_IDX, (16'h0001 << MODE_CONNECT) | (16'(pol_tab[i]) << MODE_POLARITY));
      wr(CONTROL_IDX, PRUN);
      repeat (16) @(posedge core_clk_i);
      hi = 0;
      repeat (64) begin
        @(negedge core_clk_i);
        hi += int'(pwm_pin === 1'b1);
      end
      chk(32'(hi), 32'(hi_tab[i]));
      wr(CONTROL_IDX, 16'h0);
    end
    rd(FLAGS_IDX, a);
    chk({29'h0, a[7:5]}, 32'h5);
    // reload on restart, hold when pwm run is cleared
    wr(PWM_MODULUS_IDX, 16'h0fff);
    wr(CONTROL_IDX, PRUN);
    rd(PWM_COUNT_IDX, a);
    chk({31'h0, (16'h0fff - a[15:0]) < 16'h4}, 32'h1);
    wr(CONTROL_IDX, 16'h0);
    rd(PWM_COUNT_IDX, a);
    repeat (20) @(posedge core_clk_i);
    rd(PWM_COUNT_IDX, b);
    chk(b, a);
    tally_and_finish();
  end
endmodule : gp_timer_pwm_test
